// *** design/motion_pkg.sv ***
// Purpose: constants shared by the motion axis and io control block
// Assumes: AXI4-Lite register access, 32-bit data, 4 axes
// Notes: offsets are byte addresses
package motion_pkg;
  localparam int unsigned NUM_AXES = 4;
  localparam int unsigned ADDR_W = 8;
  // register byte offsets
  localparam logic [7:0] OFF_FUNC = 8'h00;
  localparam logic [7:0] OFF_DATA = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_POS_BASE = 8'h10;
  localparam logic [7:0] OFF_ENC_BASE = 8'h20;
  localparam logic [7:0] OFF_BASEVEL_BASE = 8'h30;
  localparam logic [7:0] OFF_HEADING = 8'h40;
  localparam logic [7:0] OFF_IO_OUT = 8'h44;
  localparam logic [7:0] OFF_IO_CFG = 8'h48;
  localparam logic [7:0] OFF_AUX = 8'h4c;
  localparam logic [7:0] OFF_AXIS_CTRL = 8'h50;
  // function register fields
  localparam int unsigned FN_AXIS_LSB = 0;
  localparam int unsigned FN_ID_LSB = 8;
  localparam int unsigned FN_WCOUNT_LSB = 16;
  // function identifiers
  localparam logic [7:0] FID_ZERO_POS = 8'h01;
  localparam logic [7:0] FID_BASE_VEL = 8'h02;
  localparam logic [7:0] FID_HEADING = 8'h03;
  localparam logic [7:0] FID_LAUNCH = 8'h04;
  localparam logic [7:0] FID_IO_OUT = 8'h05;
  localparam logic [7:0] FID_AUX = 8'h06;
  localparam logic [7:0] FID_INDEX = 8'h07;
  localparam logic [1:0] MAX_WCOUNT = 2'd2;
  // floor step rate
  localparam logic [15:0] BASE_VEL_MIN = 16'd50;
  localparam logic [15:0] BASE_VEL_MAX = 16'd5000;
  localparam logic [15:0] BASE_VEL_RST = 16'd250;
  // heading encoding
  localparam logic [15:0] HEAD_FWD = 16'h0000;
  localparam logic [15:0] HEAD_REV = 16'hffff;
  // io port power-up setup: polarity 1 = inverting, direction 1 = input
  localparam logic [7:0] IO_POL_RST = 8'hff;
  localparam logic [7:0] IO_DIR_RST_SERVO = 8'hff;
  localparam logic [7:0] IO_DIR_RST_STEP = 8'h0f;
  localparam logic [7:0] IO_INHIBIT_MASK = 8'hf0;
  // step rate divider: one step enable per this many rate units of phase
  localparam int unsigned CLK_HZ = 25000000;
  localparam logic [31:0] PHASE_WRAP = 32'(CLK_HZ);
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// *** design/motion_axis_and_io_control.sv ***
// Purpose: per-axis motion control logic behind an AXI4-Lite register bus
// Assumes: single 25 MHz clock, asynchronous active-high reset
// Notes: functions are submitted by writing DATA then FUNC
//
// Function
// R1: zero-position request clears step position counter
// R2: zero-position ignored while trajectory running
// R3: closed-loop stepper also clears encoder counter
// R4: index search zeroes position, then tracks index
// R5: function carries axis, id, 0..2 words
// R6: 16-bit floor step rate, 50..5000, 250
// R7: out-of-range floor rate clamps to limit
// R8: floor rate is lowest accel/decel rate
// R9: target below floor runs fixed, no profile
// R10: heading forward 0, reverse -1, reverse default
// R11: heading honoured only in velocity mode
// R12: heading takes effect on next launch
// R13: reversing launch decelerates, turns, reaccelerates
// R14: aux write: B from 15..8, C 23..16
// R15: port C byte ignored when C is input
// R16: io output bits 7..0 map lines 8..1
// R17: pin level is output through line polarity
// R18: stepper inhibit lines untouched by output write
// R19: power-up io configuration per variant
// R20: outputs hold until write or breakpoint
// R21: closed-loop breakpoint on axis n toggles bit n
// R22: word count above two is function error
`timescale 1ns/1ns
module motion_axis_and_io_control
  import motion_pkg::*;
#(
  parameter bit IS_STEPPER = 1'b1,
  parameter bit CLOSED_LOOP_HW = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // axi4-lite write address, data and response
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // axis events
  input wire logic [NUM_AXES-1:0] breakpoint_hit,
  input wire logic [NUM_AXES-1:0] index_found,
  input wire logic [NUM_AXES-1:0] encoder_step_up,
  // motion outputs
  output logic [NUM_AXES-1:0] step_out,
  output logic [NUM_AXES-1:0] dir_out,
  // io port
  input wire logic [7:0] io_pin_in,
  output logic [7:0] io_pin_out,
  output logic [7:0] io_pin_oe,
  // auxiliary ports
  output logic [7:0] port_b_out,
  output logic [7:0] port_c_out,
  output logic port_c_oe
);

  typedef enum logic [1:0] {
    MV_IDLE,
    MV_RUN,
    MV_TURN
  } move_t;

  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [31:0] data;
    logic func_err;
    logic [NUM_AXES-1:0][31:0] pos;
    logic [NUM_AXES-1:0][31:0] enc;
    logic [NUM_AXES-1:0][15:0] base_vel;
    logic [NUM_AXES-1:0][15:0] target;
    logic [NUM_AXES-1:0][15:0] rate;
    logic [NUM_AXES-1:0][31:0] phase;
    logic [NUM_AXES-1:0] heading_set;
    logic [NUM_AXES-1:0] dir;
    logic [NUM_AXES-1:0] vel_mode;
    logic [NUM_AXES-1:0] closed_loop;
    logic [NUM_AXES-1:0] index_search;
    logic [NUM_AXES-1:0][1:0] state;
    logic [NUM_AXES-1:0] step;
    logic [7:0] io_out;
    logic [7:0] io_pol;
    logic [7:0] io_dir;
    logic [7:0] port_b;
    logic [7:0] port_c;
    logic port_c_in;
  } st_t;

  st_t st_reg;
  st_t st_next;

  function automatic logic [15:0] clamp_rate(input logic [15:0] v);
    if (v < BASE_VEL_MIN) begin
      return BASE_VEL_MIN;
    end else if (v > BASE_VEL_MAX) begin
      return BASE_VEL_MAX;
    end
    return v;
  endfunction

  function automatic logic [31:0] pack_cfg(input st_t s);
    return {16'h0000, s.io_pol, s.io_dir};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // combinational next state

  logic wr_fire;
  logic [1:0] wc;
  logic [7:0] fid;
  logic [1:0] ax;
  logic [7:0] keep;

  always_comb begin
    st_next = st_reg;
    wc = st_reg.wdata[FN_WCOUNT_LSB +: 2];
    fid = st_reg.wdata[FN_ID_LSB +: 8];
    ax = st_reg.wdata[FN_AXIS_LSB +: 2];
    // inhibit lines 5..8 stay out of reach of general writes
    keep = IS_STEPPER ? IO_INHIBIT_MASK : 8'h00;
    // write channel capture
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.aw_got = 1'b1;
      st_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.w_got = 1'b1;
      st_next.wdata = s_axi_wdata;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    wr_fire = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
    // per-axis trajectory and counters
    for (int i = 0; i < NUM_AXES; i++) begin
      st_next.step[i] = 1'b0;
      if (st_reg.state[i] != MV_IDLE) begin
        if ({1'b0, st_reg.phase[i]} + 33'(st_reg.rate[i])
            >= {1'b0, PHASE_WRAP}) begin
          st_next.phase[i] = st_reg.phase[i] + 32'(st_reg.rate[i])
                             - PHASE_WRAP;
          st_next.step[i] = 1'b1;
          st_next.pos[i] = st_reg.dir[i] ? st_reg.pos[i] - 32'd1
                                         : st_reg.pos[i] + 32'd1;
          // ramp one unit per step, never below the floor; a turn is
          // handled first so that a slow fixed-rate move can still reverse
          if (st_reg.state[i] == MV_TURN) begin
            if (st_reg.rate[i] <= st_reg.base_vel[i]) begin
              st_next.dir[i] = st_reg.heading_set[i]; // R13
              st_next.state[i] = MV_RUN;
            end else begin
              st_next.rate[i] = st_reg.rate[i] - 16'd1; // R8
            end
          end else if (st_reg.target[i] < st_reg.base_vel[i]) begin
            st_next.rate[i] = st_reg.target[i]; // R9
          end else if (st_reg.rate[i] < st_reg.target[i]) begin
            st_next.rate[i] = st_reg.rate[i] + 16'd1; // R8
          end else if (st_reg.rate[i] > st_reg.target[i]) begin
            // lowered target on a running move: ease down to it
            st_next.rate[i] = st_reg.rate[i] - 16'd1; // R8
          end
        end else begin
          st_next.phase[i] = st_reg.phase[i] + 32'(st_reg.rate[i]);
        end
      end
      if (encoder_step_up[i]) begin
        st_next.enc[i] = st_reg.enc[i] + 32'd1;
      end
      if (st_reg.index_search[i] && index_found[i]) begin
        st_next.pos[i] = 32'd0; // R4
        st_next.index_search[i] = 1'b0;
      end
      // breakpoint toggles its own output bit
      if (breakpoint_hit[i] && st_reg.closed_loop[i]) begin
        st_next.io_out[i] = ~st_next.io_out[i]; // R21 R20
      end
    end
    // register and function writes
    if (wr_fire) begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      // decode of the taken write, answered on the next edge
      if (st_reg.awaddr == OFF_DATA) begin
        st_next.data = st_reg.wdata;
      end else if (st_reg.awaddr == OFF_AXIS_CTRL) begin
        st_next.vel_mode = st_reg.wdata[3:0];
        st_next.closed_loop = CLOSED_LOOP_HW ? st_reg.wdata[7:4] : 4'h0;
      end else if (st_reg.awaddr == OFF_IO_CFG) begin
        st_next.io_pol = (st_reg.wdata[15:8] & ~keep) | (st_reg.io_pol & keep);
        st_next.io_dir = (st_reg.wdata[7:0] & ~keep) | (st_reg.io_dir & keep);
        st_next.port_c_in = st_reg.wdata[16];
      end else if (st_reg.awaddr == OFF_FUNC) begin
        if (wc > MAX_WCOUNT) begin
          st_next.func_err = 1'b1; // R22
          st_next.bresp = RESP_SLVERR;
        end else begin
          st_next.func_err = 1'b0; // R5
          if (fid == FID_ZERO_POS) begin
            if (st_reg.state[ax] == MV_IDLE) begin // R2
              st_next.pos[ax] = 32'd0; // R1
              if (IS_STEPPER && CLOSED_LOOP_HW) begin
                st_next.enc[ax] = 32'd0; // R3
              end
            end
          end else if (fid == FID_BASE_VEL) begin
            st_next.base_vel[ax] = clamp_rate(st_reg.data[15:0]); // R6 R7
          end else if (fid == FID_HEADING) begin
            if (st_reg.vel_mode[ax]) begin // R11
              st_next.heading_set[ax] = st_reg.data[15:0] == HEAD_REV; // R10
            end
          end else if (fid == FID_LAUNCH) begin
            st_next.target[ax] = st_reg.data[15:0];
            if (st_reg.state[ax] == MV_IDLE) begin
              st_next.dir[ax] = st_reg.heading_set[ax]; // R12
              st_next.state[ax] = MV_RUN;
              st_next.rate[ax] = st_reg.data[15:0] < st_reg.base_vel[ax] ?
                                 st_reg.data[15:0] : st_reg.base_vel[ax];
              st_next.phase[ax] = 32'd0;
            end else if (st_reg.heading_set[ax] != st_reg.dir[ax]) begin
              st_next.state[ax] = MV_TURN; // R13
            end
            // a zero target stops the axis at once
            if (st_reg.data[15:0] == 16'h0000) begin
              st_next.state[ax] = MV_IDLE;
            end
          end else if (fid == FID_IO_OUT) begin
            st_next.io_out = (st_reg.data[7:0] & ~keep) // R16 R18
                             | (st_next.io_out & keep);
          end else if (fid == FID_AUX) begin
            st_next.port_b = st_reg.data[15:8]; // R14
            if (!st_reg.port_c_in) begin // R15
              st_next.port_c = st_reg.data[23:16]; // R14
            end
          end else if (fid == FID_INDEX) begin
            if (st_reg.closed_loop[ax]) begin
              st_next.pos[ax] = 32'd0; // R4
              st_next.index_search[ax] = 1'b1;
            end
          end else begin
            st_next.func_err = 1'b1;
            st_next.bresp = RESP_SLVERR;
          end
        end
      end else if (st_reg.awaddr != OFF_FUNC) begin
        st_next.bresp = RESP_SLVERR;
      end
    end
    // read channel
    // a new read is only taken once the last answer has gone
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      st_next.rvalid = 1'b1;
      st_next.bresp = st_next.bresp;
      st_next.rdata = 32'h0000_0000;
      if (s_axi_araddr == OFF_DATA) begin
        st_next.rdata = st_reg.data;
      end else if (s_axi_araddr == OFF_STATUS) begin
        st_next.rdata = {23'h0, st_reg.func_err, st_reg.dir,
                         st_reg.index_search};
      end else if (s_axi_araddr == OFF_HEADING) begin
        st_next.rdata = {28'h0, st_reg.heading_set};
      end else if (s_axi_araddr == OFF_IO_OUT) begin
        st_next.rdata = {24'h0, st_reg.io_out};
      end else if (s_axi_araddr == OFF_IO_CFG) begin
        st_next.rdata = pack_cfg(st_reg) | {15'h0, st_reg.port_c_in, 16'h0};
      end else if (s_axi_araddr == OFF_AUX) begin
        st_next.rdata = {8'h0, st_reg.port_c, st_reg.port_b, 8'h0};
      end else if (s_axi_araddr == OFF_AXIS_CTRL) begin
        st_next.rdata = {24'h0, st_reg.closed_loop, st_reg.vel_mode};
      end else if (s_axi_araddr[7:4] == OFF_POS_BASE[7:4]) begin
        st_next.rdata = st_reg.pos[s_axi_araddr[3:2]];
      end else if (s_axi_araddr[7:4] == OFF_ENC_BASE[7:4]) begin
        st_next.rdata = st_reg.enc[s_axi_araddr[3:2]];
      end else if (s_axi_araddr[7:4] == OFF_BASEVEL_BASE[7:4]) begin
        st_next.rdata = {16'h0, st_reg.base_vel[s_axi_araddr[3:2]]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // power-up: floor rate, reverse heading, inverting io lines
      st_reg <= '0;
      for (int i = 0; i < NUM_AXES; i++) begin
        st_reg.base_vel[i] <= BASE_VEL_RST; // R6
      end
      st_reg.heading_set <= '1; // R10
      st_reg.io_pol <= IO_POL_RST; // R19
      st_reg.io_dir <= IS_STEPPER ? IO_DIR_RST_STEP : IO_DIR_RST_SERVO; // R19
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // each channel is refused while its word is held or answered
  assign s_axi_awready = !st_reg.aw_got && !st_reg.bvalid;
  assign s_axi_wready = !st_reg.w_got && !st_reg.bvalid;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = RESP_OKAY;
  assign step_out = st_reg.step;
  assign dir_out = st_reg.dir;
  assign io_pin_out = st_reg.io_out ^ st_reg.io_pol; // R17
  assign io_pin_oe = ~st_reg.io_dir;
  assign port_b_out = st_reg.port_b;
  assign port_c_out = st_reg.port_c;
  assign port_c_oe = !st_reg.port_c_in;

endmodule

// *** dv/host_bus_model.sv ***
// Purpose: host side register bus master
// Assumes: AXI4-Lite, one write and one read at a time
// Notes: the bench calls wr, rd and sub; r is x on a timeout
`timescale 1ns/1ns
module host_bus_model
  import motion_pkg::*;
(
  // clock
  input wire logic clk,
  // write channels
  output logic [ADDR_W-1:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // read channels
  output logic [ADDR_W-1:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  ////////////////////////////////////////
  // handshakes are judged at the falling edge, taken at the next rise
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    output logic [1:0] r);
    bit ta, tw, tk;
    r = 2'bxx;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 300; n++) begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tk = bvalid & bready;
      if (tk) r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tk) begin
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] r);
    bit ta, tk;
    r = 2'bxx;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 300; n++) begin
      @(negedge clk);
      ta = arvalid & arready;
      tk = rvalid & rready;
      v = rdata;
      if (tk) r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (tk) begin
        rready <= 1'b0;
        break;
      end
    end
  endtask
  // payload first, then the function word that runs it
  task automatic sub(input logic [1:0] ax, input logic [7:0] id,
                     input logic [1:0] wc, input logic [31:0] v,
                     output logic [1:0] r);
    wr(OFF_DATA, v, r);
    wr(OFF_FUNC, {14'h0, wc, id, 6'h0, ax}, r);
  endtask
endmodule

// *** dv/motion_axis_and_io_control_chk.sv ***
// Purpose: port level checks of the motion control block
// Assumes: single clock, reset active high
// Notes: attached by bind at the foot of this file
`timescale 1ns/1ns
module motion_axis_and_io_control_chk
  import motion_pkg::*;
#(
  parameter bit IS_STEPPER = 1'b1,
  parameter bit CLOSED_LOOP_HW = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // write bus
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // pins
  input wire logic [NUM_AXES-1:0] breakpoint_hit,
  input wire logic [7:0] io_pin_out,
  input wire logic [7:0] io_pin_oe,
  input wire logic [7:0] port_b_out,
  input wire logic [7:0] port_c_out,
  input wire logic port_c_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [ADDR_W-1:0] aw_q;
  logic [31:0] w_q;
  // last write taken, for judging its response
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_q <= '0;
      w_q <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) w_q <= s_axi_wdata;
    end
  end
  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wr_seen;
    s_axi_bvalid || $past(s_axi_wvalid);
  endsequence
  ////////////////////////////////////////
  AST_B_ANSWER: assert property (aw_w_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write not answered");
  AST_B_ONCE: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answered twice");
  AST_WCOUNT_ERR: assert property (
    $rose(s_axi_bvalid) && aw_q == OFF_FUNC && w_q[17:16] == 2'd3
    |-> s_axi_bresp == RESP_SLVERR)
    else $error("oversized payload not refused");
  AST_IO_HOLD: assert property (
    $changed(io_pin_out) |-> wr_seen or $past(|breakpoint_hit))
    else $error("io output changed without cause");
  AST_AUX_HOLD: assert property (
    $changed({port_b_out, port_c_out}) |-> wr_seen)
    else $error("aux output changed without write");
  AST_PORTC_KEEP: assert property (
    !port_c_oe && !$past(port_c_oe) |-> $stable(port_c_out))
    else $error("port c changed while input");
  AST_INHIBIT_KEEP: assert property (
    IS_STEPPER |-> $stable(io_pin_out[7:4]))
    else $error("inhibit line level changed");
  AST_INHIBIT_DIR: assert property (
    IS_STEPPER |-> io_pin_oe[7:4] == 4'hf)
    else $error("inhibit line not driven");
endmodule
bind motion_axis_and_io_control motion_axis_and_io_control_chk #(
  .IS_STEPPER(IS_STEPPER),
  .CLOSED_LOOP_HW(CLOSED_LOOP_HW)
) chk (
  .clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .breakpoint_hit(breakpoint_hit), .io_pin_out(io_pin_out),
  .io_pin_oe(io_pin_oe), .port_b_out(port_b_out),
  .port_c_out(port_c_out), .port_c_oe(port_c_oe)
);

// *** dv/motion_axis_and_io_control_tb_top.sv ***
// Purpose: self-checking bench of the motion control block
// Assumes: stepper, closed-loop variant
// Notes: floor rates of 5000 keep step spacing short
`timescale 1ns/1ns
module motion_axis_and_io_control_tb_top
  import motion_pkg::*;
;
  logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, pc_oe, d0;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d, v;
  logic [1:0] bresp, rresp, r;
  logic [NUM_AXES-1:0] bp, enc, step, dirs;
  logic [7:0] pin_out, pin_oe, pb, pc, io_m;
  int n_fail, comparisons, seed, nsteps, n;
  int flo[4];
  int vals[$];
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(negedge clk) if (step[0] === 1'b1) nsteps++;
  motion_axis_and_io_control dut (
    .clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .breakpoint_hit(bp), .index_found(4'h0), .encoder_step_up(enc),
    .step_out(step), .dir_out(dirs), .io_pin_in(8'h00),
    .io_pin_out(pin_out), .io_pin_oe(pin_oe), .port_b_out(pb),
    .port_c_out(pc), .port_c_oe(pc_oe));
  host_bus_model host (
    .clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  ////////////////////////////////////////
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    host.rd(a, d, r);
    chk({r, d}, {RESP_OKAY, e});
  endtask
  task automatic wrc(input logic [7:0] a, input logic [31:0] x,
                     input logic [1:0] er);
    host.wr(a, x, r);
    chk(r, er);
  endtask
  task automatic fn(input logic [1:0] ax, input logic [7:0] id,
                    input logic [1:0] wc, input logic [31:0] x,
                    input logic [1:0] er);
    host.sub(ax, id, wc, x, r);
    chk(r, er);
  endtask
  task automatic pulse(input logic [3:0] m, input bit to_bp);
    @(posedge clk);
    if (to_bp) bp <= m;
    else enc <= m;
    @(posedge clk);
    bp <= 4'h0;
    enc <= 4'h0;
    repeat (3) @(posedge clk);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    $display("[ERR] %0t run timed out", $time);
    results;
  end
  ////////////////////////////////////////
  initial begin
    seed = 32'hb0f5ab55;
    rst = 1'b1;
    bp = '0;
    enc = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      flo[i] = 250;
      rdc(OFF_BASEVEL_BASE + 8'(4 * i), 32'(flo[i]));
    end
    rdc(OFF_HEADING, 32'hf);
    chk({pin_oe, pin_out}, 16'hf0ff);
    $display("reset test done");
    vals = '{0, 49, 50, 5000, 65535, 0, 5001};
    vals[0] = $random(seed) & 16'hffff;
    foreach (vals[i]) begin
      fn(2'(i), FID_BASE_VEL, 2'd1, 32'(vals[i]), RESP_OKAY);
      flo[i % 4] = vals[i] < 50 ? 50 : vals[i] > 5000 ? 5000 : vals[i];
      rdc(OFF_BASEVEL_BASE + 8'(4 * (i % 4)), 32'(flo[i % 4]));
    end
    $display("floor rate test done");
    fn(2'd0, FID_ZERO_POS, 2'd3, 32'h0, RESP_SLVERR);
    rdc(OFF_STATUS, 32'h0000_0100);
    wrc(8'hfc, 32'h0, RESP_SLVERR);
    rdc(8'hf0, 32'h0);
    $display("error test done");
    repeat (3) pulse(4'h1, 1'b0);
    rdc(OFF_ENC_BASE, 32'd3);
    fn(2'd0, FID_LAUNCH, 2'd1, 32'hffff, RESP_OKAY);
    repeat (12000) @(posedge clk);
    chk(nsteps inside {[2:3]}, 1'b1);
    fn(2'd0, FID_ZERO_POS, 2'd0, 32'h0, RESP_OKAY);
    rdc(OFF_POS_BASE, 32'(-nsteps));
    rdc(OFF_ENC_BASE, 32'd3);
    fn(2'd0, FID_LAUNCH, 2'd1, 32'h0, RESP_OKAY);
    repeat (15000) @(posedge clk);
    fn(2'd0, FID_ZERO_POS, 2'd0, 32'h0, RESP_OKAY);
    rdc(OFF_POS_BASE, 32'h0);
    rdc(OFF_ENC_BASE, 32'h0);
    $display("zero position test done");
    v = $random(seed);
    fn(2'd0, FID_IO_OUT, 2'd1, {24'h0, v[7:0]}, RESP_OKAY);
    io_m = v[7:0] & 8'h0f;
    rdc(OFF_IO_OUT, 32'(io_m));
    chk(pin_out, io_m ^ 8'hff);
    pulse(4'h1, 1'b1);
    rdc(OFF_IO_OUT, 32'(io_m));
    wrc(OFF_AXIS_CTRL, 32'hf0, RESP_OKAY);
    pulse(4'h2, 1'b1);
    io_m ^= 8'h02;
    rdc(OFF_IO_OUT, 32'(io_m));
    chk(pin_out, io_m ^ 8'hff);
    $display("io output test done");
    fn(2'd2, FID_HEADING, 2'd1, HEAD_FWD, RESP_OKAY);
    rdc(OFF_HEADING, 32'hf);
    wrc(OFF_AXIS_CTRL, 32'hf4, RESP_OKAY);
    d0 = dirs[2];
    fn(2'd2, FID_HEADING, 2'd1, HEAD_FWD, RESP_OKAY);
    rdc(OFF_HEADING, 32'hb);
    chk(dirs[2], d0);
    fn(2'd2, FID_LAUNCH, 2'd1, 32'hffff, RESP_OKAY);
    repeat (12000) @(posedge clk);
    chk(dirs[2], 1'b0);
    fn(2'd2, FID_HEADING, 2'd1, HEAD_REV, RESP_OKAY);
    chk(dirs[2], 1'b0);
    fn(2'd2, FID_LAUNCH, 2'd1, 32'hffff, RESP_OKAY);
    chk(dirs[2], 1'b0);
    for (n = 0; n < 30000 && dirs[2] !== 1'b1; n++) @(posedge clk);
    chk(dirs[2], 1'b1);
    $display("heading test done");
    wrc(OFF_IO_CFG, 32'h0000ff0f, RESP_OKAY);
    fn(2'd0, FID_AUX, 2'd2, 32'hab69f1cd, RESP_OKAY);
    chk({pc_oe, pc, pb}, {1'b1, 8'h69, 8'hf1});
    wrc(OFF_IO_CFG, 32'h0001ff0f, RESP_OKAY);
    v = $random(seed);
    fn(2'd0, FID_AUX, 2'd2, v, RESP_OKAY);
    chk({pc_oe, pc, pb}, {1'b0, 8'h69, v[15:8]});
    $display("aux port test done");
    results;
  end
endmodule
